// ==== core/port7_gpio.sv ====
/*
 * port7_gpio: 8-bit port with per-bit direction and input select,
 * an output latch, and a read path muxing zero, pin level or latch.
 * assumes: pins and analog lines are synchronous to sys_clk; an
 * AXI4-Lite master issues one write and one read at a time.
 */
// The AXI4-Lite register port was left to the implementer.
// Functional notes
// - eight bits, each input or output independently
// - reset: inputs, digital select set, latch cleared
// - direction one drives pin from latch
// - both zero: analog, digital input disabled
// - input read: zero if analog, else pin
// - output read returns latch regardless of select
// - digital input feeds interrupt and wakeup lines
// - read-modify-write may copy pin into latch
// - non-analog pins stay usable as digital
`timescale 1ns/1ps

module port7_gpio
    import port7_pkg::*;
(
    input  wire logic                  sys_clk,        // 25 MHz clock
    input  wire logic                  sys_rst,        // sync, active high
    // write address channel
    input  wire logic [13:0]           s_axi_awaddr,   // byte address
    input  wire logic                  s_axi_awvalid,  // address offered
    output logic                       s_axi_awready,  // address taken
    // write data channel
    input  wire logic [31:0]           s_axi_wdata,    // write data
    input  wire logic [3:0]            s_axi_wstrb,    // byte enables
    input  wire logic                  s_axi_wvalid,   // data offered
    output logic                       s_axi_wready,   // data taken
    // write response channel
    output logic [1:0]                 s_axi_bresp,    // write response
    output logic                       s_axi_bvalid,   // response valid
    input  wire logic                  s_axi_bready,   // response taken
    // read address channel
    input  wire logic [13:0]           s_axi_araddr,   // byte address
    input  wire logic                  s_axi_arvalid,  // address offered
    output logic                       s_axi_arready,  // address taken
    // read data channel
    output logic [31:0]                s_axi_rdata,    // read data
    output logic [1:0]                 s_axi_rresp,    // read response
    output logic                       s_axi_rvalid,   // data valid
    input  wire logic                  s_axi_rready,   // data taken
    // pins, three signals each
    input  wire logic [PORT_WIDTH-1:0] port_pin_in,    // pin levels
    output logic [PORT_WIDTH-1:0]      port_pin_out,   // pin drive value
    output logic [PORT_WIDTH-1:0]      port_pin_oe,    // high: driving
    // digital input to interrupt and key-on wakeup logic
    output logic [PORT_WIDTH-1:0]      ext_event_in,   // gated pin level
    // analog enable per pin, high while digital path is off
    output logic [PORT_WIDTH-1:0]      analog_select   // pin is analog
);

    // port registers
    logic [PORT_WIDTH-1:0] data_reg;           // output latch
    logic [PORT_WIDTH-1:0] data_next;          // latch next value
    logic [PORT_WIDTH-1:0] dir_reg;            // 1 = output
    logic [PORT_WIDTH-1:0] dir_next;           // direction next
    logic [PORT_WIDTH-1:0] insel_reg;          // 1 = digital input
    logic [PORT_WIDTH-1:0] insel_next;         // select next

    // write side handshake state
    logic    aw_held_reg;                      // address captured
    logic    w_held_reg;                       // data captured
    wr_req_t wr_reg;                           // captured write
    logic    bvalid_reg;                       // response pending
    logic [1:0] bresp_reg;                     // response code
    // read side state
    logic    rvalid_reg;                       // answer pending
    rd_ans_t rd_reg;                           // answer held
    // ready flags, each straight from a flip-flop
    logic    awready_reg;                      // address slot open
    logic    wready_reg;                       // data slot open
    logic    arready_reg;                      // read slot open

    // write channel decode
    wire aw_take   = s_axi_awvalid && awready_reg;   // handshake edge
    wire w_take    = s_axi_wvalid && wready_reg;
    // open a slot the cycle after an offer, none while an answer waits
    wire aw_open   = s_axi_awvalid && !awready_reg && !aw_held_reg
                     && !bvalid_reg;
    wire w_open    = s_axi_wvalid && !wready_reg && !w_held_reg
                     && !bvalid_reg;
    wire aw_have   = aw_held_reg || aw_take;
    wire w_have    = w_held_reg || w_take;
    wire wr_fire   = aw_have && w_have && !bvalid_reg;
    wire [13:0] wr_addr = aw_held_reg ? wr_reg.addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? wr_reg.data : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_reg ? wr_reg.strb : s_axi_wstrb;
    wire wr_lane0  = wr_strb[0];               // register sits in lane 0
    wire hit_data  = wr_addr == DATA_ADDR;
    wire hit_dir   = wr_addr == DIR_ADDR;
    wire hit_insel = wr_addr == INSEL_ADDR;
    wire wr_mapped = hit_data || hit_dir || hit_insel;

    // read channel decode
    wire ar_take   = s_axi_arvalid && arready_reg;
    wire ar_open   = s_axi_arvalid && !arready_reg && !rvalid_reg;
    wire rd_data_h = s_axi_araddr == DATA_ADDR;
    wire rd_dir_h  = s_axi_araddr == DIR_ADDR;
    wire rd_ins_h  = s_axi_araddr == INSEL_ADDR;
    wire rd_mapped = rd_data_h || rd_dir_h || rd_ins_h;

    // per-bit pin modes
    wire [PORT_WIDTH-1:0] digital_in = ~dir_reg & insel_reg;
    wire [PORT_WIDTH-1:0] analog_mode = ~dir_reg & ~insel_reg;

    // port read mux: latch if output, pin if digital, else zero
    wire [PORT_WIDTH-1:0] port_view =
        (dir_reg & data_reg)
        | (digital_in & port_pin_in);

    // selected read word, upper bits zero
    wire [PORT_WIDTH-1:0] rd_byte =
        rd_data_h ? port_view :
        rd_dir_h  ? dir_reg   :
        rd_ins_h  ? insel_reg : '0;

    // register next values; lane 0 holds each 8-bit register
    assign data_next  = (wr_fire && hit_data && wr_lane0)
                        ? wr_data[PORT_WIDTH-1:0] : data_reg;
    assign dir_next   = (wr_fire && hit_dir && wr_lane0)
                        ? wr_data[PORT_WIDTH-1:0] : dir_reg;
    assign insel_next = (wr_fire && hit_insel && wr_lane0)
                        ? wr_data[PORT_WIDTH-1:0] : insel_reg;

    // port registers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            data_reg  <= DATA_RESET;
            dir_reg   <= DIR_RESET;
            insel_reg <= INSEL_RESET;
        end
        else
        begin
            data_reg  <= data_next;
            dir_reg   <= dir_next;
            insel_reg <= insel_next;
        end
    end

    // ready flags, raised the cycle after an offer is seen
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            arready_reg <= 1'b0;
        end
        else
        begin
            awready_reg <= aw_open;            // drops after one take
            wready_reg  <= w_open;
            arready_reg <= ar_open;
        end
    end

    // write address/data capture, either order
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            wr_reg      <= '0;
        end
        else if (wr_fire)
        begin
            aw_held_reg <= 1'b0;               // pair consumed
            w_held_reg  <= 1'b0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                wr_reg.addr <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held_reg  <= 1'b1;
                wr_reg.data <= s_axi_wdata;
                wr_reg.strb <= s_axi_wstrb;
            end
        end
    end

    // write response
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_reg <= 1'b0;                // response taken
        end
    end

    // read answer, taken once, held until rready
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rvalid_reg <= 1'b0;
            rd_reg     <= '0;
        end
        else if (ar_take)
        begin
            rvalid_reg   <= 1'b1;
            rd_reg.data  <= {{(32-PORT_WIDTH){1'b0}}, rd_byte};
            rd_reg.resp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    // pin and side outputs registered
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            port_pin_out  <= DATA_RESET;
            port_pin_oe   <= DIR_RESET;
            ext_event_in  <= '0;
            analog_select <= '0;
        end
        else
        begin
            port_pin_out  <= data_next;
            port_pin_oe   <= dir_next;
            ext_event_in  <= ~dir_next & insel_next & port_pin_in;
            analog_select <= ~dir_next & ~insel_next;
        end
    end

    // bus outputs
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rd_reg.data;
    assign s_axi_rresp   = rd_reg.resp;

    // assertions
    // a read of the data register, the step the read checks start from
    sequence data_read_s;
        ar_take && rd_data_h;
    endsequence

    // registers come out of reset as all digital inputs
    reset_state_a: assert property (@(posedge sys_clk)
        $past(sys_rst) |-> dir_reg == DIR_RESET && insel_reg == INSEL_RESET
        && data_reg == DATA_RESET)
        else $error("registers not at reset values");
    drive_latch_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        port_pin_oe == dir_reg && port_pin_out == data_reg)
        else $error("pin drive differs from latch");
    analog_off_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (analog_select & ext_event_in) == '0)
        else $error("analog pin feeds digital path");
    read_zero_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        data_read_s |=>
        (rd_reg.data[PORT_WIDTH-1:0] & $past(analog_mode)) == '0)
        else $error("analog bit reads non-zero");
    read_latch_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        data_read_s |=> (rd_reg.data[PORT_WIDTH-1:0] & $past(dir_reg))
        == ($past(data_reg) & $past(dir_reg)))
        else $error("output bit does not read latch");
    event_gate_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        (ext_event_in & port_pin_oe) == '0)
        else $error("event line active on output pin");
    latch_write_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        wr_fire && hit_data && wr_lane0 |=>
        data_reg == $past(wr_data[PORT_WIDTH-1:0]))
        else $error("latch not updated by write");
    // bus handshake: answer after the pair, one take per offer
    write_answer_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        wr_fire |=> bvalid_reg)
        else $error("write response missing");
    write_slot_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        aw_take |=> !awready_reg)
        else $error("address slot left open after take");
    read_slot_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        ar_take |=> !arready_reg && rvalid_reg)
        else $error("read slot left open or answer missing");

endmodule

// ==== shared/port7_pkg.sv ====
/*
 * port7_pkg: register map, reset values and bus carriers for the
 * 8-bit general-purpose port with analog input sharing.
 * assumes: an AXI4-Lite master with 32-bit data on the register side.
 */
package port7_pkg;

    localparam int          PORT_WIDTH      = 8;        // pins on the port
    localparam int          ADDR_WIDTH      = 12;       // word index bits

    // register byte addresses (printed offsets are word indices)
    localparam logic [11:0] DATA_INDEX      = 12'h007;  // port_data_latch
    localparam logic [11:0] DIR_INDEX       = 12'hf9d;  // direction control
    localparam logic [11:0] INSEL_INDEX     = 12'hf9e;  // input select
    localparam logic [13:0] DATA_ADDR       = {DATA_INDEX, 2'b00};
    localparam logic [13:0] DIR_ADDR        = {DIR_INDEX, 2'b00};
    localparam logic [13:0] INSEL_ADDR      = {INSEL_INDEX, 2'b00};

    // values after reset
    localparam logic [7:0]  DATA_RESET      = 8'h00;    // latch cleared
    localparam logic [7:0]  DIR_RESET       = 8'h00;    // all inputs
    localparam logic [7:0]  INSEL_RESET     = 8'hff;    // all digital

    // bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'b00;    // access done
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;    // unmapped address

    // write request as seen by the slave
    typedef struct packed {
        logic [13:0] addr;   // byte address
        logic [31:0] data;   // write data
        logic [3:0]  strb;   // byte enables
    } wr_req_t;

    // read answer held until taken
    typedef struct packed {
        logic [31:0] data;   // read data
        logic [1:0]  resp;   // response code
    } rd_ans_t;

endpackage

// ==== verification/port7_pins_model.sv ====
/*
 * port7_pins_model: the board side of the eight port pins.
 * assumes: pins are sampled on sys_clk; the bench sets the
 * outside levels and which lines an outside source drives.
 */
`timescale 1ns/1ps

module port7_pins_model
    import port7_pkg::*;
(
    input  wire logic                  sys_clk,   // system clock
    input  wire logic [PORT_WIDTH-1:0] pin_out,   // device drive value
    input  wire logic [PORT_WIDTH-1:0] pin_oe,    // device drives
    input  wire logic [PORT_WIDTH-1:0] ext_level, // outside level
    input  wire logic [PORT_WIDTH-1:0] ext_drive, // outside drives
    output logic [PORT_WIDTH-1:0]      pin_level  // resolved wire
);
    logic [PORT_WIDTH-1:0] float_reg;             // released lines

    // a released line has no pull: it wanders every cycle
    always_ff @(posedge sys_clk)
    begin
        float_reg <= ~pin_level;
    end

    // device drive wins on its output bits
    assign pin_level = (pin_oe & pin_out)
                     | (~pin_oe & ext_drive & ext_level)
                     | (~pin_oe & ~ext_drive & float_reg);
endmodule

// ==== verification/tb_port7_gpio_analog_mux.sv ====
/*
 * tb_port7_gpio_analog_mux: register and pin checks of the port.
 * assumes: port7_gpio and the pin model; 40 ns clock.
 */
`timescale 1ns/1ps

module tb_port7_gpio_analog_mux
    import port7_pkg::*;
;
    logic        sys_clk, sys_rst;                 // clock, reset
    logic [13:0] awaddr, araddr;                   // bus addresses
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata;                     // bus data
    logic [3:0]  wstrb;                            // byte enables
    logic [1:0]  bresp, rresp;                     // responses
    logic [7:0]  pin_in, pin_out, pin_oe, ext_ev, an_sel, ext_level;
    logic [31:0] rd_val;                           // last read data
    int          error_cnt   = 0;
    int          comparisons = 0;

    port7_gpio uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port_pin_in(pin_in),
        .port_pin_out(pin_out), .port_pin_oe(pin_oe),
        .ext_event_in(ext_ev), .analog_select(an_sel));

    port7_pins_model pins (.sys_clk(sys_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_level(ext_level), .ext_drive(8'hff),
        .pin_level(pin_in));

    // compare and count
    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write: address and data together, wait for the answer
    task wr(input logic [13:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] exp);
        logic aw_done, w_done;
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        while (!(aw_done && w_done))
        begin
            @(posedge sys_clk);
            if (awready === 1'b1) aw_done = 1'b1;
            if (wready === 1'b1) w_done = 1'b1;
            if (aw_done) awvalid <= 1'b0;
            if (w_done) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1) @(posedge sys_clk);
        bready <= 1'b0;
        chk("bresp", {30'h0, exp}, {30'h0, bresp});
    endtask

    // one read, then compare data and response
    task rd(input logic [13:0] a, input logic [31:0] exp,
            input logic [1:0] exp_r);
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        rd_val = rdata;
        rready <= 1'b0;
        chk("rdata", exp, rd_val);
        chk("rresp", {30'h0, exp_r}, {30'h0, rresp});
    endtask

    // outside pin levels, settle past the input sampling
    task set_pins(input logic [7:0] v);
        ext_level <= v;
        repeat (3) @(posedge sys_clk);
    endtask

    task t_reset;
        set_pins(8'ha5);
        chk("oe", 32'h0, {24'h0, pin_oe});
        chk("out", 32'h0, {24'h0, pin_out});
        chk("analog", 32'h0, {24'h0, an_sel});
        chk("event", 32'ha5, {24'h0, ext_ev});
        rd(DATA_ADDR, 32'ha5, RESP_OKAY);
        rd(DIR_ADDR, 32'h0, RESP_OKAY);
        rd(INSEL_ADDR, 32'hff, RESP_OKAY);
    endtask

    task t_output;
        wr(DATA_ADDR, 32'h3c, 4'hf, RESP_OKAY);
        wr(DIR_ADDR, 32'hf0, 4'hf, RESP_OKAY);
        set_pins(8'h5a);
        chk("out", 32'h3c, {24'h0, pin_out});
        chk("oe", 32'hf0, {24'h0, pin_oe});
        rd(DATA_ADDR, 32'h3a, RESP_OKAY);
        chk("event", 32'h0a, {24'h0, ext_ev});
    endtask

    // direction first, select afterwards; pin_out keeps the latch value
    task t_analog;
        wr(DIR_ADDR, 32'h03, 4'hf, RESP_OKAY);
        wr(INSEL_ADDR, 32'h0f, 4'hf, RESP_OKAY);
        set_pins(8'h5a);
        chk("analog", 32'hf0, {24'h0, an_sel});
        rd(DATA_ADDR, 32'h08, RESP_OKAY);
        chk("event", 32'h08, {24'h0, ext_ev});
        chk("out", 32'h3c, {24'h0, pin_out});
    endtask

    // bit set by read-modify-write copies pins into the latch
    task t_rmw;
        wr(INSEL_ADDR, 32'hff, 4'hf, RESP_OKAY);
        wr(DIR_ADDR, 32'h00, 4'hf, RESP_OKAY);
        set_pins(8'h81);
        rd(DATA_ADDR, 32'h81, RESP_OKAY);
        wr(DATA_ADDR, rd_val | 32'h10, 4'hf, RESP_OKAY);
        wr(DIR_ADDR, 32'hff, 4'hf, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        chk("out", 32'h91, {24'h0, pin_out});
    endtask

    // unmapped places, disabled lane, upper bits
    task t_bus;
        rd(14'h0000, 32'h0, RESP_SLVERR);
        wr(14'h0004, 32'h00, 4'hf, RESP_SLVERR);
        wr(DATA_ADDR, 32'h00, 4'h0, RESP_OKAY);
        rd(DATA_ADDR, 32'h91, RESP_OKAY);
        wr(DATA_ADDR, 32'hffffff55, 4'hf, RESP_OKAY);
        rd(DATA_ADDR, 32'h55, RESP_OKAY);
    endtask

    task report_and_stop;
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // clock source
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // hang guard, far beyond the hundred or so cycles needed
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        ext_level = 8'h00;
        sys_rst   = 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_output();
        t_analog();
        t_rmw();
        t_bus();
        report_and_stop();
    end
endmodule
